// ### logic/ubos_core.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module ubos_core
	import ubos_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// configuration image loader side
	input wire logic img_load_i,
	input wire logic img_valid_i,
	input wire logic img_from_eeprom_i,
	input wire logic [15:0] img_total_i,
	input wire logic [7:0] img_ncaps_i,
	input wire logic [7:0] img_len_i,
	input wire logic [7:0] img_type_i,
	input wire logic [31:0] img_attr_i,
	input wire logic lpm_capable_config_flag_i,
	// descriptor byte read port
	input wire logic [3:0] desc_addr_i,
	output logic [7:0] desc_data_o,
	output logic ready_o,
	output logic lpm_mismatch_o,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);
	// ==========================================
	// loaded fields
	logic [15:0] total;
	logic [7:0] ncaps;
	logic [31:0] attr_raw;
	logic loaded;
	logic sw_dis_lpm_chk;
	logic [31:0] attr;
	ubos_attr u_attr (
		.raw_i(attr_raw),
		.attr_o(attr)
	);
	wire logic use_img = img_valid_i;
	// extension content only from the eeprom image
	wire logic use_ext = img_valid_i & img_from_eeprom_i;
	wire logic [31:0] next_attr_raw = use_ext ? img_attr_i : UBOS_ATTR_DEF;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			total <= UBOS_TOTAL_DEF;
			ncaps <= UBOS_NCAPS_DEF;
			attr_raw <= UBOS_ATTR_DEF;
			loaded <= 1'b0;
		end else if (img_load_i) begin
			total <= use_img ? img_total_i : UBOS_TOTAL_DEF;
			ncaps <= use_img ? img_ncaps_i : UBOS_NCAPS_DEF;
			attr_raw <= next_attr_raw;
			loaded <= 1'b1;
		end
	end
	// ==========================================
	// descriptor byte view; img_len_i and img_type_i are never used
	logic [7:0] bytes [UBOS_DESC_BYTES];
	// forced header of the store descriptor
	assign bytes[0] = UBOS_BOS_LEN;
	assign bytes[1] = UBOS_BOS_TYPE;
	assign bytes[2] = total[7:0];
	assign bytes[3] = total[15:8];
	assign bytes[4] = ncaps;
	assign bytes[5] = UBOS_EXT_LEN;
	assign bytes[6] = UBOS_EXT_TYPE;
	assign bytes[7] = UBOS_EXT_CAP;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_attr
			assign bytes[8 + gi] = attr[8*gi +: 8];
		end
	endgenerate
	wire logic addr_ok = desc_addr_i < 4'(UBOS_DESC_BYTES);
	wire logic [7:0] next_desc = addr_ok ? bytes[desc_addr_i] : 8'h00;
	// flag a disagreement the image programmer should have avoided
	wire logic next_mismatch = loaded & ~sw_dis_lpm_chk & (attr_raw[UBOS_A_LPM] != lpm_capable_config_flag_i);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			desc_data_o <= 8'h00;
			ready_o <= 1'b0;
			lpm_mismatch_o <= 1'b0;
		end else begin
			desc_data_o <= next_desc;
			ready_o <= loaded;
			lpm_mismatch_o <= next_mismatch;
		end
	end
	// ==========================================
	// wishbone slave, one wait state
	wire logic req = cyc_i & stb_i & ~ack_o;
	wire logic wr_ctrl = req & we_i & sel_i[0] & (adr_i == UBOS_REG_CTRL);
	wire logic [31:0] rd_word =
		(adr_i == UBOS_REG_BOS0) ? {ncaps, total, 8'h00} :
		(adr_i == UBOS_REG_EXT0) ? {UBOS_EXT_CAP, UBOS_EXT_TYPE, UBOS_EXT_LEN, ncaps} :
		(adr_i == UBOS_REG_EXT1) ? attr :
		(adr_i == UBOS_REG_CTRL) ? {31'h0, sw_dis_lpm_chk} :
		(adr_i == UBOS_REG_STAT) ? {29'h0, lpm_mismatch_o, use_ext, loaded} : 32'h0000_0000;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			sw_dis_lpm_chk <= 1'b0;
		end else begin
			ack_o <= req;
			dat_o <= req ? rd_word : 32'h0000_0000;
			if (wr_ctrl) begin
				sw_dis_lpm_chk <= dat_i[0];
			end
		end
	end
	// ==========================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	bos_head_a: assert property (desc_addr_i == 4'h0 |=> desc_data_o == UBOS_BOS_LEN)
		else $error("store length not forced");
	bos_type_a: assert property (desc_addr_i == 4'h1 |=> desc_data_o == UBOS_BOS_TYPE)
		else $error("store type not forced");
	total_load_a: assert property (img_load_i && img_valid_i |=> total == $past(img_total_i))
		else $error("total length not loaded");
	ncaps_load_a: assert property (img_load_i && img_valid_i |=> ncaps == $past(img_ncaps_i))
		else $error("capability count not loaded");
	ext_head_a: assert property (desc_addr_i == 4'h6 |=> desc_data_o == UBOS_EXT_TYPE)
		else $error("extension type not forced");
	attr_resv_a: assert property ((attr & ~(UBOS_ATTR_MASK | 32'h0000_0002)) == 32'h0000_0000)
		else $error("reserved attribute bits set");
	ext_src_a: assert property (img_load_i && !img_from_eeprom_i |=> attr_raw == UBOS_ATTR_DEF)
		else $error("extension not from eeprom");
	besl_flags_a: assert property (attr[UBOS_A_DEEP_V] == attr_raw[UBOS_A_DEEP_V]
		&& attr[UBOS_A_BASE_V] == attr_raw[UBOS_A_BASE_V])
		else $error("besl valid flags altered");
	besl_lpm_a: assert property (attr[UBOS_A_BESL] |-> attr[UBOS_A_LPM])
		else $error("besl without lpm");
	lpm_set_a: assert property (desc_addr_i == 4'h8 |=> desc_data_o[UBOS_A_LPM])
		else $error("lpm bit not shown");
	dflt_a: assert property (img_load_i && !img_valid_i |=> total == UBOS_TOTAL_DEF && ncaps == UBOS_NCAPS_DEF)
		else $error("defaults not taken");
	ack_one_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	load_c: cover property (img_load_i && img_valid_i && img_from_eeprom_i);
	dflt_c: cover property (img_load_i && !img_valid_i);
	mism_c: cover property (lpm_mismatch_o);
	rd_c: cover property (ack_o && !we_i && adr_i == UBOS_REG_EXT1);
endmodule : ubos_core

// ### shared/ubos_pkg.sv
package ubos_pkg;
	// ==========================================
	// register map (word addresses on byte offsets)
	localparam logic [7:0] UBOS_REG_BOS0 = 8'h00;
	localparam logic [7:0] UBOS_REG_EXT0 = 8'h04;
	localparam logic [7:0] UBOS_REG_EXT1 = 8'h08;
	localparam logic [7:0] UBOS_REG_CTRL = 8'h0c;
	localparam logic [7:0] UBOS_REG_STAT = 8'h10;
	// ==========================================
	// forced and default values
	localparam logic [7:0] UBOS_BOS_LEN = 8'h05;
	localparam logic [7:0] UBOS_BOS_TYPE = 8'h0f;
	localparam logic [15:0] UBOS_TOTAL_DEF = 16'h0016;
	localparam logic [7:0] UBOS_NCAPS_DEF = 8'h02;
	localparam logic [7:0] UBOS_EXT_LEN = 8'h07;
	localparam logic [7:0] UBOS_EXT_TYPE = 8'h10;
	localparam logic [7:0] UBOS_EXT_CAP = 8'h02;
	localparam logic [31:0] UBOS_ATTR_DEF = 32'h0000_0006;
	// ==========================================
	// attribute field positions
	localparam int UBOS_A_LPM = 1;
	localparam int UBOS_A_BESL = 2;
	localparam int UBOS_A_BASE_V = 3;
	localparam int UBOS_A_DEEP_V = 4;
	localparam logic [31:0] UBOS_ATTR_MASK = 32'h0000_ff1e;
	localparam int UBOS_DESC_BYTES = 12;
endpackage : ubos_pkg

// ### logic/ubos_attr.sv
`timescale 1ns/1ps
module ubos_attr
	import ubos_pkg::*;
(
	input wire logic [31:0] raw_i,
	output logic [31:0] attr_o
);
	wire logic [31:0] clean = raw_i & UBOS_ATTR_MASK;
	// lpm always shown set, which also
	assign attr_o = clean | (32'h0000_0001 << UBOS_A_LPM);
endmodule : ubos_attr

// ### test/ubos_host_model.sv
`timescale 1ns/1ps
module ubos_host_model (
	input wire logic clk_i,
	input wire logic [7:0] data_i,
	output logic [3:0] addr_o
);
	logic [7:0] got [12];
	logic [3:0] deep_besl;
	initial addr_o = 4'h0;
	assign deep_besl = got[8][4] ? got[9][7:4] : 4'h0;
	// ==========================================
	// host fetch: address held two edges, byte taken at the second
	task automatic fetch();
		for (int i = 0; i < 12; i++) begin
			addr_o <= i[3:0];
			@(posedge clk_i);
			@(posedge clk_i);
			got[i] = data_i;
		end
	endtask : fetch
endmodule : ubos_host_model

// ### test/usb_bos_descriptor_builder_tb.sv
`timescale 1ns/1ps
module usb_bos_descriptor_builder_tb;
	import ubos_pkg::*;
	logic clk_i = 0, rst_i = 1, ld = 0, vld = 0, eep = 0, lpmf = 0, cyc = 0, stb = 0, we = 0, rdy, mis, ack;
	logic [15:0] tot = 0;
	logic [7:0] nc = 0, ln = 0, ty = 0, adr = 0, db;
	logic [31:0] at = 0, wd = 0, rd, q, ea;
	logic [3:0] sel = 0, da;
	int fails = 0, num_checks = 0, cycles = 0;
	always #12.5 clk_i = ~clk_i;
	ubos_host_model host (.clk_i(clk_i), .data_i(db), .addr_o(da));
	ubos_core dut (.clk_i(clk_i), .rst_i(rst_i), .img_load_i(ld), .img_valid_i(vld), .img_from_eeprom_i(eep),
		.img_total_i(tot), .img_ncaps_i(nc), .img_len_i(ln), .img_type_i(ty), .img_attr_i(at),
		.lpm_capable_config_flag_i(lpmf), .desc_addr_i(da), .desc_data_o(db), .ready_o(rdy),
		.lpm_mismatch_o(mis), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
		.dat_o(rd), .ack_o(ack));
	task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end
	// ==========================================
	// classic wishbone single read, waits for ack
	task automatic wb_rd(input logic [7:0] a, output logic [31:0] d);
		cyc <= 1; stb <= 1; we <= 0; adr <= a; sel <= 4'hf;
		do @(posedge clk_i); while (ack !== 1'b1);
		d = rd;
		cyc <= 0; stb <= 0;
		@(posedge clk_i);
	endtask : wb_rd
	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
		cyc <= 1; stb <= 1; we <= 1; adr <= a; sel <= 4'hf; wd <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk_i);
	endtask : wb_wr
	task automatic run(input logic v, input logic e, input logic [31:0] a);
		// image lpm bit kept equal to the configuration flag
		ld <= 1; vld <= v; eep <= e; at <= a; lpmf <= a[1];
		tot <= $urandom(); nc <= $urandom(); ln <= $urandom(); ty <= $urandom();
		@(posedge clk_i);
		ld <= 0;
		repeat (3) @(posedge clk_i);
		ea = (v && e) ? ((at & UBOS_ATTR_MASK) | 32'h2) : UBOS_ATTR_DEF;
		host.fetch();
		chk("ready", {31'h0, rdy}, 32'h1);
		chk("fixed", {host.got[0], host.got[1], host.got[5], host.got[6]}, 32'h050f_0710);
		chk("captype", {24'h0, host.got[7]}, 32'h2);
		chk("total", {16'h0, host.got[3], host.got[2]}, {16'h0, v ? tot : UBOS_TOTAL_DEF});
		chk("ncaps", {24'h0, host.got[4]}, {24'h0, v ? nc : UBOS_NCAPS_DEF});
		chk("attr", {host.got[11], host.got[10], host.got[9], host.got[8]}, ea);
		wb_rd(UBOS_REG_EXT1, q);
		chk("wb_attr", q, ea);
		chk("mismatch", {31'h0, mis}, {31'h0, ((v && e) ? a[1] : 1'b1) != a[1]});
		$display("test done v=%0d e=%0d", v, e);
	endtask : run
	initial begin
		void'($urandom(32'h36c3));
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		run(0, 1, 32'hffff_ffff);
		run(1, 0, 32'hffff_ffff);
		run(1, 1, 32'hffff_ffff);
		run(1, 1, 32'h0000_0004);
		for (int i = 0; i < 6; i++) run(1, 1, $urandom());
		run(0, 0, 32'h0000_0000);
		wb_wr(UBOS_REG_CTRL, 32'h0000_0001);
		wb_rd(UBOS_REG_CTRL, q);
		chk("ctrl", q, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("mismatch_off", {31'h0, mis}, 32'h0);
		wb_rd(8'h20, q);
		chk("unmapped", q, 32'h0);
		give_verdict();
	end
endmodule : usb_bos_descriptor_builder_tb
